// *** core/ble_exec.sv ***
// Branch and load execute unit with Avalon-MM register access
// Functional notes
// - Address-compare branch jumps by doubled sign-extended long offset when registers differ.
// - Compare-and-decrement jumps on inequality; first data register always decrements by one.
// - Compare-and-increment jumps on inequality; first data register always increments by one.
// - Small immediate is sign-extended to 32 bits before the compare.
// - Data non-zero branch: short offset zero-extended, medium offset sign-extended, both doubled.
// - Data zero branch: same offset forms as the non-zero branch.
// - Address non-zero branch: long offset sign-extended, short zero-extended, both doubled.
// - Address zero branch: long offset sign-extended, short zero-extended, both doubled.
// - Bit-set branch: index 0..31 long form, 0..15 implicit data register form.
// - Bit-clear branch: same index ranges and offsets as bit-set branch.
// - Address word load writes the whole fetched word to the address register.
// - Absolute address: offset bits 17:14 on top, fourteen zeros, bits 13:0 low.
// - Short base and pre-increment add sign-extended 10-bit offset; long adds 16-bit.
// - Post-increment accesses at the unmodified base register.
// - Circular and bit-reverse add odd partner low half to even base.
// - Byte loads sign- or zero-extend the fetched byte into a data register.
// - Short address loads scale 4-bit or stack 8-bit offsets by four.
// - Short post-increment address load reads at base, then base advances by four.
// - Short unsigned byte loads add unscaled offset; post form advances base by one.
`timescale 1ns/1ps
`default_nettype none
`include "ble_defines.svh"

module ble_exec
	import ble_pkg::*;
#(
	parameter int ADDR_W = 8
)
(
	input wire logic ref_clk, // 10 MHz core clock
	input wire logic rst_n, // Synchronous reset, active low
	input wire logic [ADDR_W-1:0] avs_address, // Byte address
	input wire logic avs_read, // Read request
	input wire logic avs_write, // Write request
	input wire logic [31:0] avs_writedata, // Write data
	input wire logic [3:0] avs_byteenable, // Write byte lanes
	output logic [31:0] avs_readdata, // Read data
	output logic avs_waitrequest, // Stall
	output var ble_mem_req_s mem_req, // Data memory request
	input wire logic mem_ack, // Memory answer strobe
	input wire logic [31:0] mem_rdata // Memory word, byte in [7:0]
);

	// Elaboration stops when the bus cannot reach the whole register page
	if (ADDR_W < `BLE_PAGE_BITS)
	begin : g_bad_addr_w
		$error("ADDR_W too small for the register map");
	end

	// ************************************************************
	// State
	// ************************************************************
	ble_state_e state_reg;
	ble_insn_s insn_reg;
	logic [31:0] offs_reg, pc_reg, ea_reg;
	logic [31:0] d_reg [16];
	logic [31:0] a_reg [16];
	logic taken_reg, illegal_reg, acc_reg;
	logic [31:0] readdata_reg;
	logic [3:0] dest_reg, base_idx_reg;
	logic to_addr_reg, byte_reg, signed_reg, upd_reg;
	logic [31:0] upd_val_reg;

	// ************************************************************
	// Avalon slave decode
	// ************************************************************
	logic [7:0] addr8;
	logic in_page, busy, blocked, wr_fire, rd_take;
	logic [31:0] wmerged, rd_mux;

	assign addr8 = avs_address[7:0];
	assign in_page = (avs_address >> `BLE_PAGE_BITS) == '0;
	assign busy = state_reg != BLE_ST_IDLE;
	// Writes wait while an instruction runs so operands cannot change under it
	assign blocked = avs_write & busy;
	assign avs_waitrequest = ~acc_reg;
	assign wr_fire = acc_reg & avs_write;
	assign rd_take = avs_read & ~acc_reg;
	assign avs_readdata = readdata_reg;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (be[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		end
		return r;
	endfunction : merge

	logic [3:0] gidx;
	logic hit_d, hit_a, aligned;
	assign gidx = addr8[5:2];
	assign aligned = (addr8 & `BLE_WORD_ALIGN_MASK) == 8'h00;
	assign hit_d = in_page & aligned & ((addr8 & `BLE_GPR_WIN_MASK) == `BLE_OFF_DGPR);
	assign hit_a = in_page & aligned & ((addr8 & `BLE_GPR_WIN_MASK) == `BLE_OFF_AGPR);

	always_comb
	begin
		rd_mux = 32'h0000_0000;
		if (hit_d)
			rd_mux = d_reg[gidx];
		else if (hit_a)
			rd_mux = a_reg[gidx];
		else if (in_page)
		begin
			unique case (addr8)
				`BLE_OFF_INSN: rd_mux = insn_reg;
				`BLE_OFF_OFFS: rd_mux = offs_reg;
				`BLE_OFF_PC: rd_mux = pc_reg;
				`BLE_OFF_EA: rd_mux = ea_reg;
				`BLE_OFF_STAT:
				begin
					rd_mux[`BLE_STAT_BUSY_BIT] = busy;
					rd_mux[`BLE_STAT_TAKEN_BIT] = taken_reg;
					rd_mux[`BLE_STAT_ILLEGAL_BIT] = illegal_reg;
				end
				default: rd_mux = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			acc_reg <= 1'b0;
		else
			acc_reg <= (avs_read | avs_write) & ~acc_reg & ~blocked;
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			readdata_reg <= 32'h0000_0000;
		else if (rd_take)
			readdata_reg <= rd_mux;
	end

	assign wmerged = avs_writedata;

	// ************************************************************
	// Operand fetch and offset forms
	// ************************************************************
	logic [31:0] da, ab, aa, db, d15, cmp_b;
	logic [31:0] disp_long, disp_short, disp_med;
	logic [3:0] ev_idx, od_idx;

	assign da = d_reg[insn_reg.ra];
	assign db = d_reg[insn_reg.rb];
	assign aa = a_reg[insn_reg.ra];
	assign ab = a_reg[insn_reg.rb];
	assign d15 = d_reg[`BLE_IMPLICIT_DATA_REG];
	assign cmp_b = insn_reg.use_imm ?
		{{28{insn_reg.small_immediate[3]}}, insn_reg.small_immediate} : db;
	assign disp_long = {{16{offs_reg[14]}}, offs_reg[14:0], 1'b0};
	assign disp_short = {27'h0, offs_reg[3:0], 1'b0};
	assign disp_med = {{23{offs_reg[7]}}, offs_reg[7:0], 1'b0};
	assign ev_idx = {insn_reg.rb[3:1], 1'b0};
	assign od_idx = {insn_reg.rb[3:1], 1'b1};

	// ************************************************************
	// Long-form effective address
	// ************************************************************
	logic [31:0] long_ea, sext10;
	logic long_upd, long_bad;
	assign sext10 = {{22{offs_reg[9]}}, offs_reg[9:0]};

	always_comb
	begin
		long_ea = ab;
		long_upd = 1'b0;
		long_bad = 1'b0;
		unique case (insn_reg.mode)
			BLE_EA_ABS: long_ea = {offs_reg[17:14], 14'h0, offs_reg[13:0]};
			BLE_EA_BASE_SHORT: long_ea = ab + sext10;
			BLE_EA_BASE_LONG: long_ea = ab + {{16{offs_reg[15]}}, offs_reg[15:0]};
			BLE_EA_PRE:
			begin
				long_ea = ab + sext10;
				long_upd = 1'b1;
			end
			BLE_EA_POST:
			begin
				long_ea = ab;
				long_upd = 1'b1;
			end
			BLE_EA_CIRC, BLE_EA_BREV:
			begin
				long_ea = a_reg[ev_idx] + {16'h0, a_reg[od_idx][15:0]};
				long_bad = insn_reg.rb[0];
			end
			default: long_bad = 1'b1;
		endcase
	end

	// ************************************************************
	// Instruction decode
	// ************************************************************
	logic br_taken, long_len, step_en, is_load, ld_byte, ld_signed, ld_to_addr;
	logic upd_en, bad;
	logic [31:0] disp, step_val, ld_ea, upd_val;
	logic [3:0] ld_dest, upd_idx;

	always_comb
	begin
		br_taken = 1'b0;
		long_len = 1'b1;
		disp = disp_long;
		step_en = 1'b0;
		step_val = da;
		is_load = 1'b0;
		ld_ea = ab;
		ld_byte = 1'b0;
		ld_signed = 1'b0;
		ld_dest = insn_reg.ra;
		ld_to_addr = 1'b1;
		upd_en = 1'b0;
		upd_idx = insn_reg.rb;
		upd_val = ab + sext10;
		bad = 1'b0;
		unique case (insn_reg.op)
			BLE_OP_ADDR_NE: br_taken = aa != ab;
			BLE_OP_NE_DEC:
			begin
				br_taken = da != cmp_b;
				step_en = 1'b1;
				step_val = da - `BLE_STEP_ONE;
			end
			BLE_OP_NE_INC:
			begin
				br_taken = da != cmp_b;
				step_en = 1'b1;
				step_val = da + `BLE_STEP_ONE;
			end
			BLE_OP_DNZ_SHORT, BLE_OP_DZ_SHORT:
			begin
				br_taken = (db != '0) ^ (insn_reg.op == BLE_OP_DZ_SHORT);
				long_len = 1'b0;
				disp = disp_short;
			end
			BLE_OP_DNZ_IMPL, BLE_OP_DZ_IMPL:
			begin
				br_taken = (d15 != '0) ^ (insn_reg.op == BLE_OP_DZ_IMPL);
				long_len = 1'b0;
				disp = disp_med;
			end
			BLE_OP_ANZ_LONG: br_taken = aa != '0;
			BLE_OP_AZ_LONG: br_taken = aa == '0;
			BLE_OP_ANZ_SHORT, BLE_OP_AZ_SHORT:
			begin
				br_taken = (aa != '0) ^ (insn_reg.op == BLE_OP_AZ_SHORT);
				long_len = 1'b0;
				disp = disp_short;
			end
			BLE_OP_BSET_LONG: br_taken = da[insn_reg.bit_sel];
			BLE_OP_BCLR_LONG: br_taken = ~da[insn_reg.bit_sel];
			BLE_OP_BSET_SHORT, BLE_OP_BCLR_SHORT:
			begin
				br_taken = d15[insn_reg.bit_sel[3:0]] ^ (insn_reg.op == BLE_OP_BCLR_SHORT);
				long_len = 1'b0;
				disp = disp_short;
			end
			BLE_OP_ADDR_WORD_LOAD:
			begin
				is_load = 1'b1;
				ld_ea = long_ea;
				upd_en = long_upd;
				bad = long_bad;
			end
			BLE_OP_SIGNED_BYTE_LOAD, BLE_OP_UNSIGNED_BYTE_LOAD:
			begin
				is_load = 1'b1;
				ld_byte = 1'b1;
				ld_signed = insn_reg.op == BLE_OP_SIGNED_BYTE_LOAD;
				ld_to_addr = 1'b0;
				ld_ea = long_ea;
				upd_en = long_upd;
				bad = long_bad | (insn_reg.mode == BLE_EA_BASE_LONG);
			end
			BLE_OP_AW_IND: is_load = 1'b1;
			BLE_OP_AW_IMPL_BASE:
			begin
				is_load = 1'b1;
				ld_ea = a_reg[`BLE_IMPLICIT_ADDR_REG] + {26'h0, offs_reg[3:0], 2'b00};
			end
			BLE_OP_AW_IMPL_DEST:
			begin
				is_load = 1'b1;
				ld_ea = ab + {26'h0, offs_reg[3:0], 2'b00};
				ld_dest = `BLE_IMPLICIT_ADDR_REG;
			end
			BLE_OP_AW_STACK:
			begin
				is_load = 1'b1;
				ld_ea = a_reg[`BLE_STACK_POINTER_REG] + {22'h0, offs_reg[7:0], 2'b00};
				ld_dest = `BLE_IMPLICIT_ADDR_REG;
			end
			BLE_OP_AW_POST:
			begin
				is_load = 1'b1;
				upd_en = 1'b1;
				upd_val = ab + `BLE_WORD_STEP;
			end
			BLE_OP_UB_IND, BLE_OP_UB_IMPL_BASE, BLE_OP_UB_IMPL_DEST, BLE_OP_UB_POST:
			begin
				is_load = 1'b1;
				ld_byte = 1'b1;
				ld_to_addr = 1'b0;
				if (insn_reg.op == BLE_OP_UB_IMPL_BASE)
					ld_ea = a_reg[`BLE_IMPLICIT_ADDR_REG] + {28'h0, offs_reg[3:0]};
				if (insn_reg.op == BLE_OP_UB_IMPL_DEST)
				begin
					ld_ea = ab + {28'h0, offs_reg[3:0]};
					ld_dest = `BLE_IMPLICIT_DATA_REG;
				end
				if (insn_reg.op == BLE_OP_UB_POST)
				begin
					upd_en = 1'b1;
					upd_val = ab + `BLE_BYTE_STEP;
				end
			end
			default: bad = 1'b1;
		endcase
	end

	// ************************************************************
	// Sequencer
	// ************************************************************
	logic go, done;
	assign go = wr_fire & in_page & (addr8 == `BLE_OFF_CTRL) & avs_byteenable[0]
		& avs_writedata[`BLE_CTRL_GO_BIT];
	assign done = (state_reg == BLE_ST_MEM) & mem_ack;

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			state_reg <= BLE_ST_IDLE;
		else
		begin
			unique case (state_reg)
				BLE_ST_IDLE: if (go) state_reg <= BLE_ST_EXEC;
				BLE_ST_EXEC: state_reg <= (is_load & ~bad) ? BLE_ST_MEM : BLE_ST_IDLE;
				BLE_ST_MEM: if (mem_ack) state_reg <= BLE_ST_IDLE;
				default: state_reg <= BLE_ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			taken_reg <= 1'b0;
			illegal_reg <= 1'b0;
		end
		else if (state_reg == BLE_ST_EXEC)
		begin
			taken_reg <= br_taken & ~is_load & ~bad;
			illegal_reg <= bad;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			ea_reg <= 32'h0000_0000;
			dest_reg <= 4'h0;
			base_idx_reg <= 4'h0;
			to_addr_reg <= 1'b0;
			byte_reg <= 1'b0;
			signed_reg <= 1'b0;
			upd_reg <= 1'b0;
			upd_val_reg <= 32'h0000_0000;
		end
		else if (state_reg == BLE_ST_EXEC && is_load && !bad)
		begin
			ea_reg <= ld_ea;
			dest_reg <= ld_dest;
			base_idx_reg <= upd_idx;
			to_addr_reg <= ld_to_addr;
			byte_reg <= ld_byte;
			signed_reg <= ld_signed;
			upd_reg <= upd_en;
			upd_val_reg <= upd_val;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			mem_req <= '0;
		else if (state_reg == BLE_ST_EXEC && is_load && !bad)
			mem_req <= '{req: 1'b1, byte_sel: ld_byte, addr: ld_ea};
		else if (done)
			mem_req.req <= 1'b0;
	end

	// ************************************************************
	// Software registers and program counter
	// ************************************************************
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			insn_reg <= '0;
			offs_reg <= 32'h0000_0000;
		end
		else if (wr_fire && in_page && addr8 == `BLE_OFF_INSN)
			insn_reg <= ble_insn_s'(merge(insn_reg, wmerged, avs_byteenable));
		else if (wr_fire && in_page && addr8 == `BLE_OFF_OFFS)
			offs_reg <= merge(offs_reg, wmerged, avs_byteenable);
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			pc_reg <= `BLE_PC_RST;
		else if (wr_fire && in_page && addr8 == `BLE_OFF_PC)
			pc_reg <= merge(pc_reg, wmerged, avs_byteenable);
		else if (state_reg == BLE_ST_EXEC && !is_load && !bad)
		begin
			if (br_taken)
				pc_reg <= pc_reg + disp;
			else
				pc_reg <= pc_reg + (long_len ? `BLE_LONG_INSN_LEN : `BLE_SHORT_INSN_LEN);
		end
	end

	// ************************************************************
	// General purpose registers
	// ************************************************************
	logic [31:0] ld_val;
	assign ld_val = !byte_reg ? mem_rdata :
		signed_reg ? {{24{mem_rdata[7]}}, mem_rdata[7:0]} : {24'h0, mem_rdata[7:0]};

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < 16; i++)
			begin
				d_reg[i] <= `BLE_GPR_RST;
				a_reg[i] <= `BLE_GPR_RST;
			end
		end
		else if (wr_fire && hit_d)
			d_reg[gidx] <= merge(d_reg[gidx], wmerged, avs_byteenable);
		else if (wr_fire && hit_a)
			a_reg[gidx] <= merge(a_reg[gidx], wmerged, avs_byteenable);
		else if (state_reg == BLE_ST_EXEC && step_en)
			d_reg[insn_reg.ra] <= step_val;
		else if (done)
		begin
			if (upd_reg)
				a_reg[base_idx_reg] <= upd_val_reg;
			if (to_addr_reg)
				a_reg[dest_reg] <= ld_val;
			else
				d_reg[dest_reg] <= ld_val;
		end
	end

endmodule : ble_exec
`default_nettype wire

// *** core/ble_defines.svh ***
// Register offsets, reset values and step constants for the branch and load execute unit
`ifndef BLE_DEFINES_SVH
`define BLE_DEFINES_SVH

// ************************************************************
// Register map (byte addresses)
// ************************************************************
`define BLE_PAGE_BITS 8
`define BLE_OFF_CTRL 8'h00
`define BLE_OFF_INSN 8'h04
`define BLE_OFF_OFFS 8'h08
`define BLE_OFF_PC 8'h0c
`define BLE_OFF_STAT 8'h10
`define BLE_OFF_EA 8'h14
`define BLE_OFF_DGPR 8'h40
`define BLE_OFF_AGPR 8'h80
`define BLE_GPR_WIN_MASK 8'hc0
`define BLE_WORD_ALIGN_MASK 8'h03

// ************************************************************
// Field positions and reset values
// ************************************************************
`define BLE_CTRL_GO_BIT 0
`define BLE_STAT_BUSY_BIT 0
`define BLE_STAT_TAKEN_BIT 1
`define BLE_STAT_ILLEGAL_BIT 2
`define BLE_PC_RST 32'h0000_0000
`define BLE_GPR_RST 32'h0000_0000

// ************************************************************
// Registers with a fixed role and step sizes
// ************************************************************
`define BLE_IMPLICIT_DATA_REG 4'hf
`define BLE_IMPLICIT_ADDR_REG 4'hf
`define BLE_STACK_POINTER_REG 4'ha
`define BLE_STEP_ONE 32'h0000_0001
`define BLE_WORD_STEP 32'h0000_0004
`define BLE_BYTE_STEP 32'h0000_0001
`define BLE_LONG_INSN_LEN 32'h0000_0004
`define BLE_SHORT_INSN_LEN 32'h0000_0002

`endif

// *** core/ble_pkg.sv ***
// Types shared by the branch and load execute unit
package ble_pkg;

	typedef enum logic [4:0]
	{
		BLE_OP_ADDR_NE, BLE_OP_NE_DEC, BLE_OP_NE_INC,
		BLE_OP_DNZ_SHORT, BLE_OP_DNZ_IMPL, BLE_OP_DZ_SHORT, BLE_OP_DZ_IMPL,
		BLE_OP_ANZ_LONG, BLE_OP_ANZ_SHORT, BLE_OP_AZ_LONG, BLE_OP_AZ_SHORT,
		BLE_OP_BSET_LONG, BLE_OP_BSET_SHORT, BLE_OP_BCLR_LONG, BLE_OP_BCLR_SHORT,
		BLE_OP_ADDR_WORD_LOAD, BLE_OP_SIGNED_BYTE_LOAD, BLE_OP_UNSIGNED_BYTE_LOAD,
		BLE_OP_AW_IND, BLE_OP_AW_IMPL_BASE, BLE_OP_AW_IMPL_DEST, BLE_OP_AW_STACK,
		BLE_OP_AW_POST, BLE_OP_UB_IND, BLE_OP_UB_IMPL_BASE, BLE_OP_UB_IMPL_DEST,
		BLE_OP_UB_POST
	} ble_op_e;

	typedef enum logic [2:0]
	{
		BLE_EA_ABS, BLE_EA_BASE_SHORT, BLE_EA_BASE_LONG, BLE_EA_PRE,
		BLE_EA_POST, BLE_EA_CIRC, BLE_EA_BREV
	} ble_mode_e;

	typedef enum logic [1:0]
	{
		BLE_ST_IDLE, BLE_ST_EXEC, BLE_ST_MEM
	} ble_state_e;

	typedef struct packed
	{
		logic [5:0] spare;
		logic [3:0] small_immediate;
		logic use_imm;
		logic [4:0] bit_sel;
		logic [3:0] rb;
		logic [3:0] ra;
		ble_mode_e mode;
		ble_op_e op;
	} ble_insn_s;

	typedef struct packed
	{
		logic req;
		logic byte_sel;
		logic [31:0] addr;
	} ble_mem_req_s;

endpackage : ble_pkg

// *** bench/ble_exec_assertions.sv ***
// Concurrent checks on the ports of the execute unit
`timescale 1ns/1ps
`default_nettype none
`include "ble_defines.svh"
module ble_exec_assertions
	import ble_pkg::*;
#(
	parameter int ADDR_W = 8
)
(
	input wire logic ref_clk, // Clock
	input wire logic rst_n, // Reset, active low
	input wire logic [ADDR_W-1:0] avs_address, // Byte address
	input wire logic avs_read, // Read request
	input wire logic avs_write, // Write request
	input wire logic [31:0] avs_writedata, // Write data
	input wire logic [3:0] avs_byteenable, // Write lanes
	input wire logic [31:0] avs_readdata, // Read data
	input wire logic avs_waitrequest, // Stall
	input wire ble_mem_req_s mem_req, // Memory request
	input wire logic mem_ack, // Memory answer
	input wire logic [31:0] mem_rdata // Memory word
);
	// ****
	// Shadow of the pending instruction
	// ****
	ble_insn_s insn_reg;
	logic [31:0] offs_reg;
	logic wr_ok;
	logic go;
	assign wr_ok = avs_write && !avs_waitrequest;
	assign go = wr_ok && avs_address == `BLE_OFF_CTRL && avs_writedata[0];
	// Full-word writes assumed; the bench never uses partial lanes
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			insn_reg <= '0;
			offs_reg <= '0;
		end
		else if (wr_ok && avs_address == `BLE_OFF_INSN)
			insn_reg <= avs_writedata;
		else if (wr_ok && avs_address == `BLE_OFF_OFFS)
			offs_reg <= avs_writedata;
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	property p_idle_wait;
		!avs_read && !avs_write |-> avs_waitrequest;
	endproperty
	a_idle_wait: assert property (p_idle_wait) else $error("waitrequest low without request");
	property p_read_ans;
		avs_read && avs_waitrequest |=> !avs_waitrequest;
	endproperty
	a_read_ans: assert property (p_read_ans) else $error("read not answered in one cycle");
	property p_abs_ea;
		go && insn_reg.mode == BLE_EA_ABS && insn_reg.op inside {BLE_OP_ADDR_WORD_LOAD,
			BLE_OP_SIGNED_BYTE_LOAD, BLE_OP_UNSIGNED_BYTE_LOAD} |-> ##[1:3] mem_req.req
			&& mem_req.addr == {offs_reg[17:14], 14'h0000, offs_reg[13:0]};
	endproperty
	a_abs_ea: assert property (p_abs_ea) else $error("absolute address wrong");
	property p_word_sel;
		$rose(mem_req.req) && insn_reg.op inside {BLE_OP_ADDR_WORD_LOAD, [BLE_OP_AW_IND:
			BLE_OP_AW_POST]} |-> !mem_req.byte_sel;
	endproperty
	a_word_sel: assert property (p_word_sel) else $error("word load not word wide");
	property p_byte_sel;
		$rose(mem_req.req) && insn_reg.op inside {BLE_OP_SIGNED_BYTE_LOAD,
			BLE_OP_UNSIGNED_BYTE_LOAD, [BLE_OP_UB_IND:BLE_OP_UB_POST]} |-> mem_req.byte_sel;
	endproperty
	a_byte_sel: assert property (p_byte_sel) else $error("byte load not byte wide");
	property p_req_hold;
		mem_req.req && !mem_ack |=> mem_req.req && $stable(mem_req.addr)
			&& $stable(mem_req.byte_sel);
	endproperty
	a_req_hold: assert property (p_req_hold) else $error("memory request not held");
	property p_req_done;
		mem_req.req && mem_ack |=> !mem_req.req;
	endproperty
	a_req_done: assert property (p_req_done) else $error("memory request not released");
	property p_branch_nomem;
		go && insn_reg.op < BLE_OP_ADDR_WORD_LOAD |=> !mem_req.req [*4];
	endproperty
	a_branch_nomem: assert property (p_branch_nomem) else $error("branch touched memory");
endmodule : ble_exec_assertions
bind ble_exec ble_exec_assertions #(.ADDR_W(ADDR_W)) ble_exec_assertions_inst (
	.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .mem_req(mem_req),
	.mem_ack(mem_ack), .mem_rdata(mem_rdata));
`default_nettype wire

// *** bench/ble_mem_model.sv ***
// Data memory model answering load requests after a chosen wait
`timescale 1ns/1ps
`default_nettype none
module ble_mem_model
	import ble_pkg::*;
(
	input wire logic ref_clk, // Clock
	input wire logic rst_n, // Reset, active low
	input wire ble_mem_req_s mem_req, // Request from the unit
	input wire logic [3:0] lat, // Cycles before the answer
	output logic mem_ack, // One-cycle answer
	output logic [31:0] mem_rdata // Word, byte in the low lane
);
	logic [3:0] wait_reg;
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n || !mem_req.req || mem_ack)
			wait_reg <= 4'h0;
		else
			wait_reg <= wait_reg + 4'h1;
	end
	// byte in low lane
	// Upper lanes carry junk, and data toggles outside the answer so stale data never matches
	always_comb
	begin
		mem_ack = mem_req.req && wait_reg == lat;
		mem_rdata = mem_ack ? (mem_req.addr ^ 32'hc3c3_3c3c) : ~mem_req.addr;
	end
endmodule : ble_mem_model
`default_nettype wire

// *** bench/branch_and_load_execute_tb.sv ***
// Self-checking bench for the branch and load execute unit
`timescale 1ns/1ps
`default_nettype none
`include "ble_defines.svh"
module branch_and_load_execute_tb
	import ble_pkg::*;
;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	ble_mem_req_s mem_req;
	logic mem_ack;
	logic [31:0] mem_rdata;
	logic [3:0] lat = 4'h0;
	logic [31:0] q;
	ble_insn_s x;
	int error_cnt = 0;
	int total_checks = 0;
	always #50 ref_clk = ~ref_clk;
	ble_exec #(.ADDR_W(8)) ble_exec_inst (.ref_clk(ref_clk), .rst_n(rst_n),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .mem_req(mem_req), .mem_ack(mem_ack),
		.mem_rdata(mem_rdata));
	ble_mem_model ble_mem_model_inst (.ref_clk(ref_clk), .rst_n(rst_n), .mem_req(mem_req),
		.lat(lat), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
	// ****
	// Bus access and checking
	// ****
	task automatic summarize();
		if (error_cnt == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : summarize
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e)
		begin
			error_cnt++;
			$display("[ERR] %0t got %h want %h", $time, s, e);
		end
	endtask : chk
	// Waitrequest and read data are taken at the rising edge that ends the wait
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !w;
		avs_write <= w;
		do
		begin
			@(posedge ref_clk);
			n++;
		end
		while (avs_waitrequest !== 1'b0 && n < 50);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (n >= 50)
			error_cnt++;
		@(posedge ref_clk);
	endtask : bus
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(q, e);
	endtask : rc
	task automatic run(input ble_insn_s i, input logic [31:0] off);
		int n;
		n = 0;
		bus(1'b1, `BLE_OFF_INSN, i);
		bus(1'b1, `BLE_OFF_OFFS, off);
		bus(1'b1, `BLE_OFF_CTRL, 32'h1);
		do
		begin
			bus(1'b0, `BLE_OFF_STAT, 32'h0);
			n++;
		end
		while (q[0] !== 1'b0 && n < 20);
		if (n >= 20)
			error_cnt++;
	endtask : run
	task automatic br(input ble_insn_s i, input logic [31:0] off, input logic [31:0] pc);
		bus(1'b1, `BLE_OFF_PC, 32'h100);
		run(i, off);
		rc(`BLE_OFF_PC, pc);
	endtask : br
	task automatic ld(input ble_insn_s i, input logic [31:0] off, input logic [7:0] dst,
		input logic [31:0] ea, input logic [31:0] e);
		run(i, off);
		rc(dst, e);
		rc(`BLE_OFF_EA, ea);
	endtask : ld
	function automatic ble_insn_s mk(input ble_op_e op, input logic [3:0] ra,
		input logic [3:0] rb, input logic [4:0] bs = 5'h0, input ble_mode_e m = BLE_EA_ABS);
		return '{6'h0, 4'h0, 1'b0, bs, rb, ra, m, op};
	endfunction : mk
	function automatic logic [31:0] mv(input logic [31:0] a);
		return a ^ 32'hc3c3_3c3c;
	endfunction : mv
	initial
	begin
		#2000000;
		error_cnt++;
		summarize();
	end
	initial
	begin
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		rc(`BLE_OFF_PC, 32'h0);
		rc(8'h3c, 32'h0);
		bus(1'b1, 8'h44, 32'h5);
		bus(1'b1, 8'h48, 32'h5);
		bus(1'b1, 8'h7c, 32'h8000);
		bus(1'b1, 8'h84, 32'h5);
		bus(1'b1, 8'h88, 32'h6);
		br(mk(BLE_OP_ADDR_NE, 1, 2), 32'h7fff, 32'hfe);
		rc(`BLE_OFF_STAT, 32'h2);
		br(mk(BLE_OP_ADDR_NE, 1, 1), 32'h7fff, 32'h104);
		br(mk(BLE_OP_NE_DEC, 1, 2), 32'h10, 32'h104);
		rc(8'h44, 32'h4);
		br(mk(BLE_OP_NE_DEC, 1, 2), 32'h10, 32'h120);
		rc(8'h44, 32'h3);
		x = mk(BLE_OP_NE_INC, 2, 2);
		x.use_imm = 1'b1;
		x.small_immediate = 4'hf;
		br(x, 32'h1, 32'h102);
		rc(8'h48, 32'h6);
		bus(1'b1, 8'h48, 32'hffff_ffff);
		br(x, 32'h1, 32'h104);
		rc(8'h48, 32'h0);
		br(mk(BLE_OP_DNZ_SHORT, 15, 15), 32'hf, 32'h11e);
		br(mk(BLE_OP_DNZ_IMPL, 15, 15), 32'h80, 32'h0);
		br(mk(BLE_OP_DZ_SHORT, 3, 3), 32'h8, 32'h110);
		br(mk(BLE_OP_DZ_IMPL, 15, 15), 32'h8, 32'h102);
		br(mk(BLE_OP_ANZ_LONG, 1, 1), 32'h4000, 32'hffff_8100);
		br(mk(BLE_OP_ANZ_SHORT, 0, 0), 32'hf, 32'h102);
		br(mk(BLE_OP_AZ_SHORT, 0, 0), 32'hf, 32'h11e);
		br(mk(BLE_OP_AZ_LONG, 1, 1), 32'h8, 32'h104);
		br(mk(BLE_OP_BSET_LONG, 15, 15, 31), 32'h8, 32'h104);
		br(mk(BLE_OP_BSET_LONG, 15, 15, 15), 32'h8, 32'h110);
		br(mk(BLE_OP_BSET_SHORT, 15, 15, 31), 32'h3, 32'h106);
		br(mk(BLE_OP_BCLR_LONG, 15, 15, 31), 32'h7ffe, 32'hfc);
		br(mk(BLE_OP_BCLR_SHORT, 15, 15, 15), 32'h3, 32'h102);
		bus(1'b1, 8'h88, 32'h1000);
		bus(1'b1, 8'h90, 32'h2000);
		bus(1'b1, 8'h94, 32'habcd_1234);
		bus(1'b1, 8'hbc, 32'h300);
		bus(1'b1, 8'ha8, 32'h400);
		lat <= 4'h3;
		ld(mk(BLE_OP_ADDR_WORD_LOAD, 3, 2), 32'h3c005, 8'h8c, 32'hf000_0005,
			mv(32'hf000_0005));
		ld(mk(BLE_OP_ADDR_WORD_LOAD, 3, 2, 0, BLE_EA_BASE_SHORT), 32'h3fc, 8'h8c, 32'hffc,
			mv(32'hffc));
		ld(mk(BLE_OP_ADDR_WORD_LOAD, 3, 2, 0, BLE_EA_BASE_LONG), 32'h8000, 8'h8c,
			32'hffff_9000, mv(32'hffff_9000));
		// base and destination kept apart in update modes
		ld(mk(BLE_OP_ADDR_WORD_LOAD, 3, 2, 0, BLE_EA_PRE), 32'h10, 8'h8c, 32'h1010,
			mv(32'h1010));
		rc(8'h88, 32'h1010);
		lat <= 4'h0;
		ld(mk(BLE_OP_ADDR_WORD_LOAD, 3, 2, 0, BLE_EA_POST), 32'h3f0, 8'h8c, 32'h1010,
			mv(32'h1010));
		rc(8'h88, 32'h1000);
		ld(mk(BLE_OP_ADDR_WORD_LOAD, 3, 4, 0, BLE_EA_CIRC), 32'h0, 8'h8c, 32'h3234,
			mv(32'h3234));
		ld(mk(BLE_OP_ADDR_WORD_LOAD, 3, 4, 0, BLE_EA_BREV), 32'h0, 8'h8c, 32'h3234,
			mv(32'h3234));
		run(mk(BLE_OP_ADDR_WORD_LOAD, 3, 5, 0, BLE_EA_CIRC), 32'h0);
		rc(`BLE_OFF_STAT, 32'h4);
		ld(mk(BLE_OP_SIGNED_BYTE_LOAD, 3, 2), 32'h80, 8'h4c, 32'h80, 32'hffff_ffbc);
		ld(mk(BLE_OP_UNSIGNED_BYTE_LOAD, 3, 2), 32'h80, 8'h4c, 32'h80, 32'hbc);
		lat <= 4'h2;
		ld(mk(BLE_OP_AW_IMPL_BASE, 3, 3), 32'hf, 8'h8c, 32'h33c, mv(32'h33c));
		ld(mk(BLE_OP_AW_STACK, 3, 3), 32'hff, 8'hbc, 32'h7fc, mv(32'h7fc));
		ld(mk(BLE_OP_AW_POST, 3, 2), 32'h0, 8'h8c, 32'h1000, mv(32'h1000));
		rc(8'h88, 32'h1004);
		ld(mk(BLE_OP_UB_IMPL_DEST, 2, 2), 32'hf, 8'h7c, 32'h1013, 32'h2f);
		ld(mk(BLE_OP_UB_POST, 3, 2), 32'h0, 8'h4c, 32'h1004, 32'h38);
		rc(8'h88, 32'h1005);
		ld(mk(BLE_OP_AW_IND, 3, 4), 32'h0, 8'h8c, 32'h2000, mv(32'h2000));
		ld(mk(BLE_OP_UB_IMPL_BASE, 3, 3), 32'h5, 8'h4c, 32'hc3c3_3bc5, 32'hf9);
		run(mk(BLE_OP_UNSIGNED_BYTE_LOAD, 3, 2, 0, BLE_EA_BASE_LONG), 32'h0);
		rc(`BLE_OFF_STAT, 32'h4);
		summarize();
	end
endmodule : branch_and_load_execute_tb
`default_nettype wire
